// file: rcm_pkg.sv
// rcm_pkg: constants for the repeater configuration-source and settings control
// assumes a single 100 MHz clock domain; no register bus, all controls are ports
package rcm_pkg;

  // ----------------------------------------------------------------
  // four-level pin codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LVL_ZERO = 2'h0; // low resistor to ground
  localparam logic [1:0] LVL_R = 2'h1; // high resistor to ground
  localparam logic [1:0] LVL_FLOAT = 2'h2; // pin left open
  localparam logic [1:0] LVL_ONE = 2'h3; // tied high

  // ----------------------------------------------------------------
  // configuration modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RCM_PIN = 2'b00,
    RCM_SLAVE = 2'b01,
    RCM_MASTER = 2'b10
  } rcm_mode_t;

  // ----------------------------------------------------------------
  // load sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RCM_LD_IDLE = 2'b00,
    RCM_LD_BUSY = 2'b01,
    RCM_LD_DONE = 2'b10
  } rcm_load_t;

  // ----------------------------------------------------------------
  // rate codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_GEN12 = 2'h0;
  localparam logic [1:0] RATE_GEN3_NODE = 2'h1;
  localparam logic [1:0] RATE_AUTO = 2'h2;
  localparam logic [1:0] RATE_GEN3_DE = 2'h3;

  // ----------------------------------------------------------------
  // register defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] EQ_RESET = 8'h00;
  localparam logic [1:0] DEEMPH_RESET = 2'h0;
  localparam logic [2:0] SWING_RESET = 3'h2;
  localparam logic [1:0] TERM_RESET = 2'h2; // automatic detect, float default
  localparam logic [1:0] SDTH_RESET = 2'h0; // low-pin default threshold code
  localparam logic [1:0] RATE_RESET = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int BUS_CLK_NOM_HZ = 400000;
  localparam int BUS_CLK_MIN_HZ = 280000;
  localparam int BUS_CLK_MAX_HZ = 520000;
  // half period of the generated bus clock, rounded to stay inside the band
  localparam int BUS_HALF_CYC = CLK_HZ / (2 * BUS_CLK_NOM_HZ);
  localparam int READY_MS = 500;
  localparam int READY_CYC = (CLK_HZ / 1000) * READY_MS;

endpackage

// file: rcm_config_ctrl.sv
// rcm_config_ctrl: selects where repeater lane settings come from
// assumes all pins are synchronous to i_mclk and four-level pins arrive decoded
// What this block does
// RULE1 - three modes from config source: low pin, high slave, float master
// RULE2 - pin mode: eq and deemphasis per side, shared across that side's lanes
// RULE3 - pin mode: swing follows the deemphasis pin code automatically
// RULE4 - termination pin selects automatic or manual 50 ohm / high-z termination
// RULE5 - rate pin selects gen1/2, auto detect, or gen3
// RULE6 - threshold pin selects electrical-idle detect level
// RULE7 - slave mode: swing, eq, deemphasis, termination disable per lane; each write sets one lane index on both sides together
// RULE8 - config source high switches eq and deemphasis to registers at once
// RULE9 - bus modes reuse eq and deemphasis pins as slave address inputs
// RULE10 - rate, termination, threshold pins act until register written with override
// RULE11 - registers reset at power-up and whenever config source goes low
// RULE12 - cable present in slave mode keeps all register contents
// RULE13 - eight-bit eq per input, sixteen reachable from pins; code reaches four, each pin feeding both table halves
// RULE14 - control pins decode four levels
// RULE15 - master mode drives bus clock near 400 kHz, inside 280 to 520
// RULE16 - host clocks the bus no faster than 400 kHz
// RULE17 - bus ready no later than 500 ms after reset
// RULE18 - pin levels: low resistor 0, high resistor R, open Float, high 1
// RULE19 - master load starts on falling edge of read enable
`timescale 1ns/100ps
`default_nettype none

module rcm_config_ctrl #(
  parameter int LANES = 4,
  parameter int READY_CYCLES = rcm_pkg::READY_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // four-level pins, already resolved to level codes; cable present and read enable are single bits
  input wire logic [1:0] i_config_source_select,
  input wire logic [1:0] i_side_a_eq_level,
  input wire logic [1:0] i_side_b_eq_level,
  input wire logic [1:0] i_side_a_deemph_level,
  input wire logic [1:0] i_side_b_deemph_level,
  input wire logic [1:0] i_termination_detect_ctrl,
  input wire logic [1:0] i_rate,
  input wire logic [1:0] i_signal_detect_threshold,
  input wire logic i_cable_present,
  input wire logic i_read_en,
  // register write port from the bus slave logic
  input wire logic i_reg_wr,
  input wire logic [1:0] i_reg_lane,
  input wire logic [7:0] i_reg_eq,
  input wire logic [1:0] i_reg_deemph,
  input wire logic [2:0] i_reg_swing,
  input wire logic i_reg_term_dis,
  input wire logic i_glb_wr,
  input wire logic [1:0] i_glb_rate,
  input wire logic i_glb_rate_ovr,
  input wire logic [1:0] i_glb_term,
  input wire logic i_glb_term_ovr,
  input wire logic [1:0] i_glb_sdth,
  input wire logic i_glb_sdth_ovr,
  // load sequencer handshake
  input wire logic i_load_done,
  // mode and bus outputs
  output logic [1:0] o_mode,
  output logic [3:0] o_slave_address_inputs,
  output logic o_bus_ready,
  output logic o_master_scl,
  output logic o_load_busy,
  // per-lane settings, side a in lanes 0..LANES-1, side b above
  output logic [2*LANES*8-1:0] o_eq,
  output logic [2*LANES*2-1:0] o_deemph,
  output logic [2*LANES*3-1:0] o_output_swing,
  output logic [2*LANES-1:0] o_term_dis,
  // shared settings
  output logic [1:0] o_rate,
  output logic [1:0] o_term_mode,
  output logic [1:0] o_sdth
);

  localparam int NL = 2 * LANES;

  // ----------------------------------------------------------------
  // pin decode helpers
  // ----------------------------------------------------------------
  // RULE13 sixteen pin eq
  function automatic logic [7:0] eq_of_pins(input logic [1:0] hi, input logic [1:0] lo);
    logic [7:0] t;
    t = 8'h00;
    case ({hi, lo})
      4'h0: t = 8'h00;
      4'h1: t = 8'h01;
      4'h2: t = 8'h02;
      4'h3: t = 8'h03;
      4'h4: t = 8'h07;
      4'h5: t = 8'h15;
      4'h6: t = 8'h0B;
      4'h7: t = 8'h0F;
      4'h8: t = 8'h55;
      4'h9: t = 8'h1F;
      4'hA: t = 8'h2F;
      4'hB: t = 8'h3F;
      4'hC: t = 8'hAA;
      4'hD: t = 8'h7F;
      4'hE: t = 8'hBF;
      default: t = 8'hFF;
    endcase
    return t;
  endfunction

  // deemphasis code: 0 none, 1 -3.5, 2 -6, 3 -9 dB
  function automatic logic [1:0] dem_of_pins(input logic [1:0] hi, input logic [1:0] lo);
    logic [1:0] t;
    t = 2'h0;
    case ({hi, lo})
      4'h2, 4'h4, 4'h7, 4'hA, 4'hD: t = 2'h1;
      4'h5, 4'h8, 4'hB, 4'hE: t = 2'h2;
      4'hF: t = 2'h3;
      default: t = 2'h0;
    endcase
    return t;
  endfunction

  // swing code: 0 = 0.8 V up to 5 = 1.3 V in 0.1 V steps
  function automatic logic [2:0] swing_of_pins(input logic [1:0] hi, input logic [1:0] lo);
    logic [2:0] t;
    t = 3'h0;
    case ({hi, lo})
      4'h0: t = 3'h0;
      4'h1, 4'h2: t = 3'h1;
      4'h3, 4'h4, 4'h5: t = 3'h2;
      4'h6, 4'h7, 4'h8: t = 3'h3;
      4'h9, 4'hA, 4'hB: t = 3'h4;
      default: t = 3'h5;
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // RULE1 mode select
  // RULE14 four levels
  // RULE18 level mapping
  rcm_pkg::rcm_mode_t mode;
  always_comb begin
    case (i_config_source_select)
      rcm_pkg::LVL_ONE: mode = rcm_pkg::RCM_SLAVE;
      rcm_pkg::LVL_FLOAT: mode = rcm_pkg::RCM_MASTER;
      default: mode = rcm_pkg::RCM_PIN; // the R level is treated as low
    endcase
  end
  assign o_mode = mode;

  logic pin_mode;
  assign pin_mode = (mode == rcm_pkg::RCM_PIN);

  // RULE9 pins become address
  // eq b pins give ad3/ad2, deemph b pins ad1/ad0; a high code is a logic 1
  assign o_slave_address_inputs = pin_mode ? 4'h0 :
    {i_side_b_eq_level[1], i_side_b_eq_level[0] & i_side_b_eq_level[1],
     i_side_b_deemph_level[1], i_side_b_deemph_level[0] & i_side_b_deemph_level[1]};

  // ----------------------------------------------------------------
  // per-lane register file
  // ----------------------------------------------------------------
  logic [7:0] reg_eq [NL];
  logic [1:0] reg_deemph [NL];
  logic [2:0] reg_swing [NL];
  logic reg_term_dis [NL];
  logic [1:0] lane_base;

  // one lane index addresses the same lane on both sides at once
  assign lane_base = i_reg_lane;

  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_lane
      // RULE11 default on pin mode
      // RULE12 retained while cable present
      // RULE7 per lane write
      // pin mode holds defaults; a reset from cable-present is never applied
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          reg_eq[g] <= rcm_pkg::EQ_RESET;
          reg_deemph[g] <= rcm_pkg::DEEMPH_RESET;
          reg_swing[g] <= rcm_pkg::SWING_RESET;
          reg_term_dis[g] <= 1'b0;
        end else if (pin_mode) begin
          reg_eq[g] <= rcm_pkg::EQ_RESET;
          reg_deemph[g] <= rcm_pkg::DEEMPH_RESET;
          reg_swing[g] <= rcm_pkg::SWING_RESET;
          reg_term_dis[g] <= 1'b0;
        end else if (i_reg_wr &&
                     (int'(lane_base) == (g % LANES))) begin
          reg_eq[g] <= i_reg_eq;
          reg_deemph[g] <= i_reg_deemph;
          reg_swing[g] <= i_reg_swing;
          reg_term_dis[g] <= i_reg_term_dis;
        end
      end

      // RULE2 shared per side
      // RULE3 swing follows deemph
      // RULE8 registers at once
      // mode decode is combinational, so registers drive the lanes from the next edge
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_eq[g*8 +: 8] <= rcm_pkg::EQ_RESET;
          o_deemph[g*2 +: 2] <= rcm_pkg::DEEMPH_RESET;
          o_output_swing[g*3 +: 3] <= rcm_pkg::SWING_RESET;
          o_term_dis[g] <= 1'b0;
        end else if (!pin_mode) begin
          o_eq[g*8 +: 8] <= reg_eq[g];
          o_deemph[g*2 +: 2] <= reg_deemph[g];
          o_output_swing[g*3 +: 3] <= reg_swing[g];
          o_term_dis[g] <= reg_term_dis[g];
        end else if (g < LANES) begin
          o_eq[g*8 +: 8] <= eq_of_pins(i_side_a_eq_level, i_side_a_eq_level);
          o_deemph[g*2 +: 2] <= dem_of_pins(i_side_a_deemph_level, i_side_a_deemph_level);
          o_output_swing[g*3 +: 3] <= swing_of_pins(i_side_a_deemph_level,
                                                    i_side_a_deemph_level);
          o_term_dis[g] <= 1'b0;
        end else begin
          o_eq[g*8 +: 8] <= eq_of_pins(i_side_b_eq_level, i_side_b_eq_level);
          o_deemph[g*2 +: 2] <= dem_of_pins(i_side_b_deemph_level, i_side_b_deemph_level);
          o_output_swing[g*3 +: 3] <= swing_of_pins(i_side_b_deemph_level,
                                                    i_side_b_deemph_level);
          o_term_dis[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // shared settings with pin override
  // ----------------------------------------------------------------
  logic [1:0] reg_rate;
  logic [1:0] reg_term;
  logic [1:0] reg_sdth;
  logic ovr_rate;
  logic ovr_term;
  logic ovr_sdth;

  // RULE10 override latch
  // override bits stay set until pin mode is entered again
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      reg_rate <= rcm_pkg::RATE_RESET;
      reg_term <= rcm_pkg::TERM_RESET;
      reg_sdth <= rcm_pkg::SDTH_RESET;
      ovr_rate <= 1'b0;
      ovr_term <= 1'b0;
      ovr_sdth <= 1'b0;
    end else if (pin_mode) begin
      reg_rate <= rcm_pkg::RATE_RESET;
      reg_term <= rcm_pkg::TERM_RESET;
      reg_sdth <= rcm_pkg::SDTH_RESET;
      ovr_rate <= 1'b0;
      ovr_term <= 1'b0;
      ovr_sdth <= 1'b0;
    end else if (i_glb_wr) begin
      reg_rate <= i_glb_rate;
      reg_term <= i_glb_term;
      reg_sdth <= i_glb_sdth;
      ovr_rate <= ovr_rate | i_glb_rate_ovr;
      ovr_term <= ovr_term | i_glb_term_ovr;
      ovr_sdth <= ovr_sdth | i_glb_sdth_ovr;
    end
  end

  // RULE4 termination select
  // RULE5 rate select
  // RULE6 threshold select
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rate <= rcm_pkg::RATE_RESET;
      o_term_mode <= rcm_pkg::TERM_RESET;
      o_sdth <= rcm_pkg::SDTH_RESET;
    end else begin
      o_rate <= ovr_rate ? reg_rate : i_rate;
      o_term_mode <= ovr_term ? reg_term : i_termination_detect_ctrl;
      o_sdth <= ovr_sdth ? reg_sdth : i_signal_detect_threshold;
    end
  end

  // ----------------------------------------------------------------
  // power-on readiness
  // ----------------------------------------------------------------
  // RULE17 ready timer
  // ready well before the limit is fine; the count is a parameter to shorten sims
  logic [31:0] rdy_cnt;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdy_cnt <= 32'h0;
      o_bus_ready <= 1'b0;
    end else if (rdy_cnt >= 32'(READY_CYCLES - 1)) begin
      o_bus_ready <= 1'b1;
    end else begin
      rdy_cnt <= rdy_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // master load sequencing
  // ----------------------------------------------------------------
  logic read_en_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      read_en_q <= 1'b1;
    end else begin
      read_en_q <= i_read_en;
    end
  end

  // RULE19 falling edge start
  rcm_pkg::rcm_load_t ld_state;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ld_state <= rcm_pkg::RCM_LD_IDLE;
    end else if (mode != rcm_pkg::RCM_MASTER) begin
      ld_state <= rcm_pkg::RCM_LD_IDLE;
    end else begin
      case (ld_state)
        rcm_pkg::RCM_LD_IDLE: begin
          if (read_en_q && !i_read_en && o_bus_ready) begin
            ld_state <= rcm_pkg::RCM_LD_BUSY;
          end
        end
        rcm_pkg::RCM_LD_BUSY: begin
          if (i_load_done) begin
            ld_state <= rcm_pkg::RCM_LD_DONE;
          end
        end
        rcm_pkg::RCM_LD_DONE: ld_state <= rcm_pkg::RCM_LD_DONE;
        default: ld_state <= rcm_pkg::RCM_LD_IDLE;
      endcase
    end
  end
  assign o_load_busy = (ld_state == rcm_pkg::RCM_LD_BUSY);

  // RULE15 bus clock divider
  // 125 cycles per half gives 400 kHz; the clock idles high outside a load
  logic [15:0] div_cnt;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt <= 16'h0;
      o_master_scl <= 1'b1;
    end else if (ld_state != rcm_pkg::RCM_LD_BUSY) begin
      div_cnt <= 16'h0;
      o_master_scl <= 1'b1;
    end else if (div_cnt == 16'(rcm_pkg::BUS_HALF_CYC - 1)) begin
      div_cnt <= 16'h0;
      o_master_scl <= ~o_master_scl;
    end else begin
      div_cnt <= div_cnt + 16'h1;
    end
  end

endmodule

`default_nettype wire

// file: rcm_chk.sv
// rcm_chk: concurrent checks on the configuration control ports
// assumes it is bound to rcm_config_ctrl and sees only its ports
`timescale 1ns/100ps
`default_nettype none

module rcm_chk #(
  parameter int LANES = 4,
  parameter int READY_CYCLES = rcm_pkg::READY_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // pins
  input wire logic [1:0] i_config_source_select,
  input wire logic [1:0] i_termination_detect_ctrl,
  input wire logic [1:0] i_rate,
  input wire logic [1:0] i_signal_detect_threshold,
  input wire logic i_cable_present,
  input wire logic i_read_en,
  input wire logic i_reg_wr,
  // outputs
  input wire logic [1:0] o_mode,
  input wire logic [3:0] o_slave_address_inputs,
  input wire logic o_bus_ready,
  input wire logic o_master_scl,
  input wire logic o_load_busy,
  input wire logic [2*LANES*8-1:0] o_eq,
  input wire logic [1:0] o_rate,
  input wire logic [1:0] o_term_mode,
  input wire logic [1:0] o_sdth
);
  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  int unsigned up_cnt;
  // cycles since reset release; saturates so a long run never wraps
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      up_cnt <= 0;
    end else if (up_cnt < READY_CYCLES + 4) begin
      up_cnt <= up_cnt + 1;
    end
  end
  a_slave_mode: assert property (
    i_config_source_select == rcm_pkg::LVL_ONE |-> o_mode == rcm_pkg::RCM_SLAVE)
    else $error("high config source is not slave mode");
  a_master_mode: assert property (
    i_config_source_select == rcm_pkg::LVL_FLOAT |-> o_mode == rcm_pkg::RCM_MASTER)
    else $error("open config source is not master mode");
  a_pin_noaddr: assert property (
    o_mode == rcm_pkg::RCM_PIN |-> o_slave_address_inputs == 4'h0)
    else $error("address shown in pin mode");
  a_ready_late: assert property (
    up_cnt >= READY_CYCLES + 2 |-> o_bus_ready)
    else $error("bus not ready in time");
  a_pins_follow: assert property (
    (o_mode == rcm_pkg::RCM_PIN && $stable({i_rate, i_termination_detect_ctrl,
      i_signal_detect_threshold})) [*3] |-> o_rate == i_rate &&
      o_term_mode == i_termination_detect_ctrl && o_sdth == i_signal_detect_threshold)
    else $error("shared settings do not follow pins");
  a_slave_eq_reg: assert property (
    o_mode == rcm_pkg::RCM_SLAVE && $past(o_mode) == rcm_pkg::RCM_PIN |->
      ##2 o_eq == {2*LANES{rcm_pkg::EQ_RESET}})
    else $error("eq not taken from registers");
  a_retain: assert property (
    o_mode == rcm_pkg::RCM_SLAVE && $stable(o_mode) && i_cable_present &&
      !$past(i_reg_wr) |=> $stable(o_eq))
    else $error("eq lost while cable present");
  a_load_start: assert property (
    o_bus_ready && o_mode == rcm_pkg::RCM_MASTER && $fell(i_read_en) |-> ##[0:2] o_load_busy)
    else $error("load did not start");
  a_scl_idle: assert property (
    !o_load_busy && !$past(o_load_busy) |-> o_master_scl)
    else $error("bus clock low outside load");
  a_scl_high: assert property (
    o_load_busy && $rose(o_master_scl) |=> o_master_scl [*8])
    else $error("bus clock high phase too short");
  c_load: cover property (o_load_busy && $rose(o_master_scl));
  c_retain: cover property (o_mode == rcm_pkg::RCM_SLAVE && i_cable_present);
  c_ready: cover property ($rose(o_bus_ready));
endmodule

bind rcm_config_ctrl rcm_chk #(.LANES(LANES), .READY_CYCLES(READY_CYCLES)) u_chk (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_config_source_select(i_config_source_select),
  .i_termination_detect_ctrl(i_termination_detect_ctrl), .i_rate(i_rate),
  .i_signal_detect_threshold(i_signal_detect_threshold), .i_cable_present(i_cable_present),
  .i_read_en(i_read_en), .i_reg_wr(i_reg_wr), .o_mode(o_mode),
  .o_slave_address_inputs(o_slave_address_inputs), .o_bus_ready(o_bus_ready),
  .o_master_scl(o_master_scl), .o_load_busy(o_load_busy), .o_eq(o_eq), .o_rate(o_rate),
  .o_term_mode(o_term_mode), .o_sdth(o_sdth)
);
`default_nettype wire

// file: rcm_host.sv
// rcm_host: management bus host model driving the register write port
// assumes the bench calls its tasks; the block samples on i_mclk rising edges
`timescale 1ns/100ps
`default_nettype none

module rcm_host #(
  parameter int GAP = 4
) (
  // clock
  input wire logic i_mclk,
  // lane and shared register writes
  output logic o_reg_wr,
  output logic [1:0] o_reg_lane,
  output logic [7:0] o_reg_eq,
  output logic [1:0] o_reg_deemph,
  output logic [2:0] o_reg_swing,
  output logic o_reg_term_dis,
  output logic o_glb_wr,
  output logic [5:0] o_glb, // rate, term, threshold
  output logic [2:0] o_ovr // rate, term, threshold
);
  // --------------------------------------------------------------
  // write tasks
  // --------------------------------------------------------------
  // idle values at time zero
  initial begin
    o_reg_wr = 1'b0;
    o_glb_wr = 1'b0;
    {o_reg_lane, o_reg_eq, o_reg_deemph, o_reg_swing, o_reg_term_dis} = 16'h0000;
    {o_glb, o_ovr} = 9'h000;
  end
  task automatic lane_wr(input logic [1:0] ln, input logic [7:0] eq, input logic [1:0] dem,
    input logic [2:0] sw, input logic dis);
    @(posedge i_mclk);
    o_reg_wr <= 1'b1;
    {o_reg_lane, o_reg_eq, o_reg_deemph, o_reg_swing, o_reg_term_dis} <= {ln, eq, dem, sw, dis};
    @(posedge i_mclk);
    o_reg_wr <= 1'b0;
    // released eq and swing data are inverted so a late sample cannot pass by luck
    {o_reg_eq, o_reg_swing} <= ~{eq, sw};
    repeat (GAP) @(posedge i_mclk);
  endtask
  task automatic glb_wr(input logic [5:0] v, input logic [2:0] ov);
    @(posedge i_mclk);
    o_glb_wr <= 1'b1;
    {o_glb, o_ovr} <= {v, ov};
    @(posedge i_mclk);
    o_glb_wr <= 1'b0;
    {o_glb, o_ovr} <= ~{v, ov};
    repeat (GAP) @(posedge i_mclk);
  endtask
endmodule
`default_nettype wire

// file: repeater_config_mode_control_bench.sv
// repeater_config_mode_control_bench: self-checking bench for rcm_config_ctrl
// assumes rcm_host.sv drives the write port and rcm_chk is bound to the block
`timescale 1ns/100ps
`default_nettype none

module repeater_config_mode_control_bench;
  // ----------------------------------------------------------------
  // stimulus, design and checks
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int READY = 20;
  localparam int LO = rcm_pkg::CLK_HZ / (2 * rcm_pkg::BUS_CLK_MAX_HZ);
  localparam int HI = rcm_pkg::CLK_HZ / (2 * rcm_pkg::BUS_CLK_MIN_HZ) + 1;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic [1:0] cfg = 2'h0, eqa = 2'h0, eqb = 2'h0, dma = 2'h0, dmb = 2'h0;
  logic [1:0] term = 2'h2, rate = 2'h2, sdth = 2'h0;
  logic cable = 1'b0, rd_en = 1'b1, ld_done = 1'b0;
  logic wr, rdis, gwr, ready, scl, busy;
  logic [1:0] lane, rdem, mode, rate_q, term_q, sdth_q;
  logic [7:0] req, tdis;
  logic [2:0] rsw, ovr;
  logic [5:0] glb;
  logic [3:0] addr;
  logic [63:0] eq;
  logic [23:0] sw;
  logic [15:0] dem;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] eq_tab [4] = '{8'h00, 8'h15, 8'h2F, 8'hFF};
  logic [2:0] sw_tab [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
  logic [1:0] dm_tab [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  logic [1:0] md_tab [4] = '{rcm_pkg::RCM_PIN, rcm_pkg::RCM_PIN, rcm_pkg::RCM_MASTER,
    rcm_pkg::RCM_SLAVE};
  // free-running clock
  always #5 i_mclk = ~i_mclk;
  rcm_host host (.i_mclk(i_mclk), .o_reg_wr(wr), .o_reg_lane(lane), .o_reg_eq(req),
    .o_reg_deemph(rdem), .o_reg_swing(rsw), .o_reg_term_dis(rdis), .o_glb_wr(gwr),
    .o_glb(glb), .o_ovr(ovr));
  rcm_config_ctrl #(.LANES(LANES), .READY_CYCLES(READY)) DUT (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_config_source_select(cfg),
    .i_side_a_eq_level(eqa), .i_side_b_eq_level(eqb), .i_side_a_deemph_level(dma),
    .i_side_b_deemph_level(dmb), .i_termination_detect_ctrl(term), .i_rate(rate),
    .i_signal_detect_threshold(sdth), .i_cable_present(cable), .i_read_en(rd_en),
    .i_reg_wr(wr), .i_reg_lane(lane), .i_reg_eq(req), .i_reg_deemph(rdem),
    .i_reg_swing(rsw), .i_reg_term_dis(rdis), .i_glb_wr(gwr), .i_glb_rate(glb[5:4]),
    .i_glb_rate_ovr(ovr[2]), .i_glb_term(glb[3:2]), .i_glb_term_ovr(ovr[1]),
    .i_glb_sdth(glb[1:0]), .i_glb_sdth_ovr(ovr[0]), .i_load_done(ld_done),
    .o_mode(mode), .o_slave_address_inputs(addr), .o_bus_ready(ready),
    .o_master_scl(scl), .o_load_busy(busy), .o_eq(eq), .o_deemph(dem),
    .o_output_swing(sw), .o_term_dis(tdis), .o_rate(rate_q), .o_term_mode(term_q),
    .o_sdth(sdth_q));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  // waits past the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic t_reset();
    #1;
    chk({eq[7:0], sw[2:0], rate_q, term_q, sdth_q, scl, ready},
      {rcm_pkg::EQ_RESET, rcm_pkg::SWING_RESET, rcm_pkg::RATE_RESET, rcm_pkg::TERM_RESET,
      rcm_pkg::SDTH_RESET, 2'b10}, "reset");
    @(posedge i_mclk);
    i_nrst <= 1'b1;
    tick(READY + 3);
    chk(ready, 1'b1, "ready");
    $display("t_reset done");
  endtask
  task automatic t_mode();
    for (int c = 0; c < 4; c++) begin
      @(posedge i_mclk);
      cfg <= 2'(c);
      tick(1);
      chk(mode, md_tab[c], "mode");
    end
    @(posedge i_mclk);
    cfg <= 2'h0;
    $display("t_mode done");
  endtask
  task automatic t_pin();
    for (int k = 0; k < 4; k++) begin
      @(posedge i_mclk);
      {eqa, dma, eqb, dmb} <= {2'(k), 2'(k), 2'(3 - k), 2'(3 - k)};
      tick(3);
      chk(eq, {{4{eq_tab[3 - k]}}, {4{eq_tab[k]}}}, "pin eq");
      chk(sw, {{4{sw_tab[3 - k]}}, {4{sw_tab[k]}}}, "pin swing");
      chk(dem, {{4{dm_tab[3 - k]}}, {4{dm_tab[k]}}}, "pin deemph");
    end
    $display("t_pin done");
  endtask
  task automatic t_slave();
    host.lane_wr(2'h1, 8'hA5, 2'h1, 3'h4, 1'b1);
    tick(2);
    chk(eq[15:8], eq_tab[3], "write refused in pin mode");
    @(posedge i_mclk);
    cfg <= 2'h3;
    eqb <= 2'h3;
    tick(2);
    chk(eq, {8{rcm_pkg::EQ_RESET}}, "eq from registers");
    chk(addr, 4'hC, "slave address");
    host.lane_wr(2'h1, 8'hA5, 2'h1, 3'h4, 1'b1);
    chk({eq[47:40], eq[15:8], eq[7:0], sw[5:3], tdis, dem[11:10], dem[3:2]},
      {16'hA5A5, rcm_pkg::EQ_RESET, 3'h4, 8'h22, 4'h5}, "lane write");
    @(posedge i_mclk);
    cable <= 1'b1;
    tick(5);
    chk(eq[15:8], 8'hA5, "retained");
    @(posedge i_mclk);
    cable <= 1'b0;
    $display("t_slave done");
  endtask
  task automatic t_override();
    @(posedge i_mclk);
    rate <= 2'h0;
    tick(3);
    chk(rate_q, 2'h0, "rate pin in slave");
    host.glb_wr({2'h3, 2'h1, 2'h3}, 3'b011);
    chk({rate_q, term_q, sdth_q}, {2'h0, 2'h1, 2'h3}, "override");
    @(posedge i_mclk);
    term <= 2'h3;
    tick(3);
    chk(term_q, 2'h1, "pin ignored");
    @(posedge i_mclk);
    cfg <= 2'h0;
    tick(3);
    chk({term_q, eq[7:0]}, {2'h3, eq_tab[3]}, "pin mode again");
    @(posedge i_mclk);
    cfg <= 2'h3;
    tick(2);
    chk(eq[15:8], rcm_pkg::EQ_RESET, "registers cleared");
    $display("t_override done");
  endtask
  task automatic t_master();
    logic s0;
    int n;
    @(posedge i_mclk);
    cfg <= 2'h2;
    @(posedge i_mclk);
    rd_en <= 1'b0;
    for (n = 0; n < 5 && busy !== 1'b1; n++) tick(1);
    chk(busy, 1'b1, "load start");
    s0 = scl;
    for (n = 0; n < 400 && scl === s0; n++) tick(1);
    s0 = scl;
    for (n = 0; n < 400 && scl === s0; n++) tick(1);
    chk(n >= LO && n <= HI, 1'b1, "bus clock half period");
    @(posedge i_mclk);
    ld_done <= 1'b1;
    @(posedge i_mclk);
    {ld_done, rd_en} <= 2'b01;
    tick(3);
    chk({busy, scl}, 2'b01, "load end");
    $display("t_master done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence after three cycles of reset
  initial begin
    repeat (3) @(posedge i_mclk);
    t_reset();
    t_mode();
    t_pin();
    t_slave();
    t_override();
    t_master();
    results();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    results();
  end
endmodule
`default_nettype wire
